// File: rtl/sewp_pkg.sv
// Shared constants and types of the serial word port: frame layout,
// command codes, storage shape and programming time.
// Assumes a 250 MHz system clock that samples every pin.
package sewp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] SEWP_START_PAT  = 4'ha;   // Start pattern 1010
  localparam int         SEWP_OPC_BITS   = 4;
  localparam int         SEWP_ADDR_BITS  = 8;
  localparam int         SEWP_DATA_BITS  = 16;
  localparam logic [3:0] SEWP_OPC_LAST   = 4'h3;   // Bit count of last opcode bit
  localparam logic [3:0] SEWP_ADDR_LAST  = 4'h7;   // Bit count of last address bit
  localparam logic [3:0] SEWP_DATA_LAST  = 4'hf;   // Bit count of last data bit

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [3:0] SEWP_OPC_READ   = 4'h8;   // 1000
  localparam logic [3:0] SEWP_OPC_WRITE  = 4'h4;   // 0100
  localparam logic [3:0] SEWP_OPC_WRITE_ENABLE_CMD  = 4'h3;  // 0011
  localparam logic [3:0] SEWP_OPC_WRITE_DISABLE_CMD = 4'h0;  // 0000

  // ----------------------------------------------------------------
  // Storage and reset values
  // ----------------------------------------------------------------
  localparam int          SEWP_WORDS     = 256;
  localparam logic [15:0] SEWP_ERASED    = 16'hffff; // Erased word value
  localparam logic        SEWP_WEN_RST   = 1'b0;     // Writes disabled at power-up
  localparam logic [1:0]  SEWP_SYNC_RST  = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SEWP_SYS_CLK_MHZ   = 250;
  localparam int SEWP_WRITE_TIME_MS = 10;          // Self-timed write cycle
  localparam int SEWP_WRITE_CYCLES  = SEWP_WRITE_TIME_MS * 1000 * SEWP_SYS_CLK_MHZ;

  // ----------------------------------------------------------------
  // Frame parser states, Gray along hunt, opcode, address, data
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEWP_ST_HUNT = 3'h0,
    SEWP_ST_OPC  = 3'h1,
    SEWP_ST_ADDR = 3'h3,
    SEWP_ST_DATA = 3'h2,
    SEWP_ST_READ = 3'h6,
    SEWP_ST_DONE = 3'h7
  } sewp_state_t;

endpackage

// File: rtl/sewp_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to sys_clk; only q may be read.
`timescale 1ns/1ns
`default_nettype none
module sewp_sync #(
  parameter logic RST_VAL = 1'b0                  // Level shown during reset
) (
  input  wire logic sys_clk,                      // System clock
  input  wire logic rst,                          // Async reset, active high
  input  wire logic d,                            // Raw pin
  output var  logic q                             // Synchronised level
);
  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/sewp_prog_timer.sv
// Self-timed programming cycle counter.
// Assumes start and abort are one-cycle pulses on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module sewp_prog_timer #(
  parameter int CYCLES = 2500000                  // Length of a write cycle
) (
  input  wire logic sys_clk,                      // System clock
  input  wire logic rst,                          // Async reset, active high
  input  wire logic start,                        // Begin a cycle
  input  wire logic abort,                        // Cut the cycle short
  output var  logic busy,                         // Cycle running
  output var  logic done                          // Pulse at normal end
);
  logic [31:0] cnt_q;

  // Runs on sys_clk only, so the serial clock may stop during programming
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= 32'(CYCLES - 1);
        busy  <= 1'b1;
      end else if (busy && abort) begin
        busy  <= 1'b0;
      end else if (busy) begin
        if (cnt_q == 32'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/sewp_word_port.sv
// Serial word port: frame parser, 256 x 16 word store, write enable,
// hardware write lock and self-timed programming with status on two pins.
// Assumes all pins are asynchronous to sys_clk and toggle far slower than it.
//
// Overview of operation
// - Sample serial input on rising clock, change serial output on falling clock.
// - Frame is start 1010, 4-bit opcode, 8-bit address, MSB first.
// - Write frame carries exactly 16 data bits after the address.
// - Bits before the start pattern are ignored.
// - Decode read 1000, write 0100 and the two enable commands.
// - 0011 sets, 0000 clears write enable; address ignored; off at power-up.
// - Write enable persists until cleared; enable commands do not touch reads.
// - Writes execute only while write enable is set, else discarded.
// - Storage is 256 words of 16 bits, chosen by the address.
// - Read loads the word into the output shifter; only reads shift data out.
// - A write erases the word before programming the new data.
// - Programming starts at the 32nd rising edge, timed internally.
// - Ready/busy low within 1 us of edge 32 until done, then high.
// - No serial clock needed during programming.
// - Chip select falling with serial clock low while programming shows status on serial output.
// - After programming a poll shows high; first serial input rise ends it.
// - Lock pin low permits writes, high blocks them and shows ready status.
// - Lock pin change during programming aborts the write.
// - Lock pin does not affect read or enable commands.
`timescale 1ns/1ns
`default_nettype none
module sewp_word_port #(
  parameter int WRITE_CYCLES = sewp_pkg::SEWP_WRITE_CYCLES  // System clocks per write cycle
) (
  input  wire logic sys_clk,                      // System clock, 250 MHz
  input  wire logic rst,                          // Async reset, active high
  input  wire logic cs_n,                         // Chip select pin, active low
  input  wire logic sck,                          // Serial clock pin
  input  wire logic si,                           // Serial input pin
  input  wire logic write_lock_n,                 // Low permits writes
  output var  logic so_out,                       // Serial output level
  output var  logic so_oe,                        // Serial output enable
  output var  logic rdy_busy                      // High ready, low busy
);
  import sewp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wl_n_s;
  logic cs_n_prev_q;
  logic sck_prev_q;
  logic si_prev_q;

  sewp_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (cs_n),
    .q       (cs_n_s)
  );
  sewp_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (sck),
    .q       (sck_s)
  );
  sewp_sync #(.RST_VAL(1'b0)) u_sync_si (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (si),
    .q       (si_s)
  );
  sewp_sync #(.RST_VAL(1'b1)) u_sync_wl (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (write_lock_n),
    .q       (wl_n_s)
  );

  // Previous synchronised levels for edge finding
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_n_prev_q <= 1'b1;
      sck_prev_q  <= 1'b0;
      si_prev_q   <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sck_prev_q  <= sck_s;
      si_prev_q   <= si_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic si_rise;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign cs_fall  = ~cs_n_s & cs_n_prev_q;
  assign si_rise  = si_s & ~si_prev_q;

  // ----------------------------------------------------------------
  // Programming timer
  // ----------------------------------------------------------------
  logic prog_start;
  logic prog_abort;
  logic prog_busy;
  logic prog_done;
  logic wl_at_start_q;

  sewp_prog_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (prog_start),
    .abort   (prog_abort),
    .busy    (prog_busy),
    .done    (prog_done)
  );

  // Lock pin captured at start; any change later aborts the cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wl_at_start_q <= 1'b0;
    end else if (prog_start) begin
      wl_at_start_q <= wl_n_s;
    end
  end
  assign prog_abort = prog_busy & (wl_n_s != wl_at_start_q);

  // ----------------------------------------------------------------
  // Frame parser
  // ----------------------------------------------------------------
  sewp_state_t state_q;
  logic [3:0]  hunt_q;                            // Last four bits while hunting
  logic [3:0]  bit_cnt_q;                         // Bit index in the current field
  logic [15:0] in_sr_q;                           // Input shifter
  logic [3:0]  opc_q;
  logic [7:0]  addr_q;
  logic        wen_q;                             // Write enable state
  logic        frame_ok;
  logic [3:0]  hunt_next;
  logic [15:0] in_next;

  // Parse only while selected and idle; programming freezes new frames
  assign frame_ok  = ~cs_n_s & ~prog_busy & sck_rise;
  assign hunt_next = {hunt_q[2:0], si_s};
  assign in_next   = {in_sr_q[14:0], si_s};       // MSB first

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= SEWP_ST_HUNT;
      hunt_q    <= 4'h0;
      bit_cnt_q <= 4'h0;
      in_sr_q   <= 16'h0;
      opc_q     <= 4'h0;
      addr_q    <= 8'h0;
    end else if (cs_n_s) begin
      // Deselect drops any partial frame
      state_q   <= SEWP_ST_HUNT;
      hunt_q    <= 4'h0;
      bit_cnt_q <= 4'h0;
    end else if (frame_ok) begin
      unique case (state_q)
        SEWP_ST_HUNT: begin
          hunt_q <= hunt_next;
          if (hunt_next == SEWP_START_PAT) begin
            state_q   <= SEWP_ST_OPC;
            bit_cnt_q <= 4'h0;
          end
        end
        SEWP_ST_OPC: begin
          in_sr_q   <= in_next;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == SEWP_OPC_LAST) begin
            opc_q     <= in_next[3:0];
            state_q   <= SEWP_ST_ADDR;
            bit_cnt_q <= 4'h0;
          end
        end
        SEWP_ST_ADDR: begin
          in_sr_q   <= in_next;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == SEWP_ADDR_LAST) begin
            addr_q    <= in_next[7:0];
            bit_cnt_q <= 4'h0;
            unique case (opc_q)
              SEWP_OPC_READ:  state_q <= SEWP_ST_READ;
              SEWP_OPC_WRITE: state_q <= SEWP_ST_DATA;
              default:        state_q <= SEWP_ST_DONE;
            endcase
          end
        end
        SEWP_ST_DATA: begin
          in_sr_q   <= in_next;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == SEWP_DATA_LAST) begin
            state_q <= SEWP_ST_DONE;              // Extra bits are ignored
          end
        end
        SEWP_ST_READ: begin
          state_q <= SEWP_ST_READ;
        end
        SEWP_ST_DONE: begin
          state_q <= SEWP_ST_DONE;
        end
        default: begin
          state_q <= SEWP_ST_HUNT;
        end
      endcase
    end
  end

  // Decode strobes, each one cycle wide
  logic addr_end;
  logic data_end;
  assign addr_end = frame_ok & (state_q == SEWP_ST_ADDR) & (bit_cnt_q == SEWP_ADDR_LAST);
  assign data_end = frame_ok & (state_q == SEWP_ST_DATA) & (bit_cnt_q == SEWP_DATA_LAST);

  // Write enable: the lock pin plays no part here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wen_q <= SEWP_WEN_RST;
    end else if (addr_end && opc_q == SEWP_OPC_WRITE_ENABLE_CMD) begin
      wen_q <= 1'b1;
    end else if (addr_end && opc_q == SEWP_OPC_WRITE_DISABLE_CMD) begin
      wen_q <= 1'b0;
    end
  end

  // The 32nd rising edge starts programming when both guards allow it
  assign prog_start = data_end & wen_q & ~wl_n_s;

  // ----------------------------------------------------------------
  // Word store
  // ----------------------------------------------------------------
  logic [15:0] mem_q [SEWP_WORDS];
  logic [15:0] prog_data_q;
  logic [7:0]  prog_addr_q;
  logic [15:0] rd_word;

  assign rd_word = mem_q[in_next[7:0]];           // Address as it completes

  // Pending word held for the whole cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_data_q <= 16'h0;
      prog_addr_q <= 8'h0;
    end else if (prog_start) begin
      prog_data_q <= in_next;
      prog_addr_q <= addr_q;
    end
  end

  // Store is not reset; an aborted word stays erased, which is not guaranteed data
  always_ff @(posedge sys_clk) begin
    if (prog_start) begin
      mem_q[addr_q] <= SEWP_ERASED;
    end else if (prog_done) begin
      mem_q[prog_addr_q] <= prog_data_q;
    end
  end

  // ----------------------------------------------------------------
  // Status polling
  // ----------------------------------------------------------------
  logic poll_q;                                   // Status shown on serial output
  logic post_write_q;                             // Write finished, not yet acknowledged

  // Finished write remembered until a poll is ended by a rise on serial input or a new write starts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      post_write_q <= 1'b0;
    end else if (prog_done) begin
      post_write_q <= 1'b1;                       // Set wins over the clear
    end else if (prog_start || (poll_q && si_rise)) begin
      post_write_q <= 1'b0;
    end
  end

  // Poll starts on select with the serial clock low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      poll_q <= 1'b0;
    end else if (cs_n_s) begin
      poll_q <= 1'b0;
    end else if (cs_fall && !sck_s && (prog_busy || post_write_q || wl_n_s)) begin
      poll_q <= 1'b1;
    end else if (poll_q && !prog_busy && si_rise) begin
      poll_q <= 1'b0;
    end else if (addr_end && opc_q == SEWP_OPC_READ) begin
      poll_q <= 1'b0;                             // Read data takes the pin
    end
  end

  // ----------------------------------------------------------------
  // Serial output and ready/busy pin
  // ----------------------------------------------------------------
  logic [15:0] out_sr_q;
  logic        rd_active;

  assign rd_active = ~cs_n_s & (state_q == SEWP_ST_READ);

  // Output shifter loads at the end of a read address, shifts on falling edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_sr_q <= 16'h0;
    end else if (addr_end && opc_q == SEWP_OPC_READ) begin
      out_sr_q <= rd_word;
    end else if (rd_active && sck_fall) begin
      out_sr_q <= {out_sr_q[14:0], 1'b0};
    end
  end

  // Pin drive: read data first, else polled status, else released
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else if (rd_active) begin
      so_oe <= 1'b1;
      if (sck_fall) begin
        so_out <= out_sr_q[15];
      end
    end else if (poll_q && !cs_n_s) begin
      so_oe  <= 1'b1;
      so_out <= ~prog_busy;
    end else begin
      so_oe  <= 1'b0;
      so_out <= 1'b0;
    end
  end

  // Busy one cycle after the 32nd edge is seen, well inside the 1 us bound
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdy_busy <= 1'b1;
    end else if (prog_start) begin
      rdy_busy <= 1'b0;
    end else begin
      rdy_busy <= ~prog_busy;
    end
  end

endmodule
`default_nettype wire

// File: sim/sewp_host_model.sv
// Host model: drives chip select, serial clock and serial input.
// Assumes each task starts on a rising sys_clk edge.
`timescale 1ns/1ns
`default_nettype none
module sewp_host_model (
  input  wire logic sys_clk, // System clock
  input  wire logic so,      // Resolved serial output
  output var  logic cs_n,    // Chip select, active low
  output var  logic sck,     // Serial clock, idles low
  output var  logic si       // Serial input
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Shift n bits MSB first; so is taken just before each rise
  task automatic frame(input int n, input logic [39:0] b, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n <= 1'b0;
    tick(16);
    for (int i = n - 1; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= b[i];
      tick(16);
      rd = {rd[14:0], so};
      sck <= 1'b1;
      tick(15);
    end
    sck <= 1'b0;
    tick(16);
  endtask
  // Long deselect also leaves the clock low long enough to poll
  task automatic deselect();
    cs_n <= 1'b1;
    tick(260);
  endtask
  task automatic select();
    cs_n <= 1'b0;
    tick(8);
  endtask
  task automatic si_rise();
    si <= 1'b0;
    tick(4);
    si <= 1'b1;
    tick(8);
  endtask
endmodule
`default_nettype wire

// File: sim/sewp_word_port_chk.sv
// Pin-level assertions of the serial word port.
// Bound to sewp_word_port; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module sewp_chk #(
  parameter int WRITE_CYCLES = 600 // Busy length in sys_clk
) (
  input wire logic sys_clk,      // System clock
  input wire logic rst,          // Async reset
  input wire logic cs_n,         // Chip select
  input wire logic sck,          // Serial clock
  input wire logic si,           // Serial input
  input wire logic write_lock_n, // Lock pin
  input wire logic so_out,       // Serial output
  input wire logic so_oe,        // Output enable
  input wire logic rdy_busy      // Ready/busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int   busy_q;
  logic lk_q;
  // Busy length, and whether the lock moved (an abort may end it early)
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 0;
      lk_q   <= 1'b0;
    end else begin
      busy_q <= rdy_busy ? 0 : busy_q + 1;
      lk_q   <= !rdy_busy && (lk_q || write_lock_n != $past(write_lock_n));
    end
  end
  sequence s_poll; !rdy_busy && $fell(cs_n) && !sck; endsequence
  sequence s_status(v); ##[1:8] (so_oe && so_out == v); endsequence
  property p_poll; s_poll |-> s_status(1'b0); endproperty
  a_poll: assert property (p_poll) else $error("no busy status on poll");
  property p_done; $rose(rdy_busy) && !cs_n && so_oe |-> s_status(1'b1); endproperty
  a_done: assert property (p_done) else $error("no ready status at end");
  property p_len; $rose(rdy_busy) && !lk_q |-> busy_q >= WRITE_CYCLES - 1 && busy_q <= WRITE_CYCLES + 1; endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_abort; !rdy_busy && $changed(write_lock_n) |-> ##[1:8] rdy_busy; endproperty
  a_abort: assert property (p_abort) else $error("lock change did not abort");
  property p_lock; $fell(rdy_busy) |-> !write_lock_n && !$past(write_lock_n, 6); endproperty
  a_lock: assert property (p_lock) else $error("write ran while locked");
  property p_start; $fell(rdy_busy) |-> sck && !cs_n && !$past(sck, 8); endproperty
  a_start: assert property (p_start) else $error("busy not after a rise");
  property p_release; $rose(cs_n) |-> ##[1:8] !so_oe; endproperty
  a_release: assert property (p_release) else $error("so held after deselect");
  property p_si; rdy_busy && so_oe && !sck && $rose(si) |-> ##[1:8] !so_oe; endproperty
  a_si: assert property (p_si) else $error("si rise kept status");
  property p_edge; so_oe && $past(so_oe) && $changed(so_out) && rdy_busy |-> !sck; endproperty
  a_edge: assert property (p_edge) else $error("so moved with clock high");
endmodule
bind sewp_word_port sewp_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.sys_clk(sys_clk), .rst(rst),
  .cs_n(cs_n), .sck(sck), .si(si), .write_lock_n(write_lock_n), .so_out(so_out), .so_oe(so_oe),
  .rdy_busy(rdy_busy));
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench of the serial word port against a word model.
// Assumes sewp_host_model drives the pins and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
  import sewp_pkg::*;
  localparam int PROG_CYC = 1700; // Short write cycle, still long enough to send a frame while busy
  logic        sys_clk;
  logic        rst;
  logic        write_lock_n;
  wire logic   cs_n;
  wire logic   sck;
  wire logic   si;
  wire logic   so;
  logic        so_out;
  logic        so_oe;
  logic        rdy_busy;
  logic [15:0] mem_m [SEWP_WORDS];
  logic        wen_m;
  logic [15:0] rd;
  logic [15:0] d;
  int          failures;
  int          n_compared;
  int          cyc;
  assign so = so_oe ? so_out : 1'bz;
  sewp_word_port #(.WRITE_CYCLES(PROG_CYC)) dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck),
    .si(si), .write_lock_n(write_lock_n), .so_out(so_out), .so_oe(so_oe), .rdy_busy(rdy_busy));
  sewp_host_model host (.sys_clk(sys_clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // n above 32 sends the last n-32 bits of junk 0000 0100 first; n below 32 cuts the frame short
  task automatic send(input int n, input logic [3:0] op, input logic [7:0] ad, input logic [15:0] dt);
    logic [39:0] b;
    b = {4'h0, 4'h4, SEWP_START_PAT, op, ad, dt};
    if (n < 32) b = b >> (32 - n);
    host.frame(n, b, rd);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
    logic ok;
    ok = wen_m && !write_lock_n;
    send(32, SEWP_OPC_WRITE, ad, dt);
    `CHK("busy", !ok, rdy_busy)
    if (ok) mem_m[ad] = dt;
    host.deselect();
  endtask
  task automatic idle();
    for (int i = 0; i < 2000 && rdy_busy !== 1'b1; i++) @(posedge sys_clk);
    `CHK("ready", 1'b1, rdy_busy)
  endtask
  task automatic rdw(input logic [7:0] ad);
    send(36, SEWP_OPC_READ, ad, 16'h0000);
    `CHK("read", mem_m[ad], rd)
    host.deselect();
  endtask
  task automatic cmd(input logic [3:0] op);
    send(32, op, 8'($urandom), 16'h0000);
    host.deselect();
  endtask
  initial begin
    logic [7:0] al [3];
    rst = 1'b1;
    write_lock_n = 1'b0;
    wen_m = 1'b0;
    failures = 0;
    n_compared = 0;
    cyc = 0;
    void'($urandom(32'haeb032a8));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK("ready", 1'b1, rdy_busy)
    `CHK("so_oe", 1'b0, so_oe)
    wr(8'h5a, 16'h1234);
    $display("test reset done");
    cmd(SEWP_OPC_WRITE_ENABLE_CMD);
    wen_m = 1'b1;
    al = '{8'h00, 8'hff, 8'($urandom)};
    foreach (al[k]) begin
      wr(al[k], 16'($urandom));
      if (k == 0) begin
        cmd(SEWP_OPC_WRITE_DISABLE_CMD);
        host.select();
        `CHK("poll", 1'b0, so)
        idle();
        repeat (8) @(posedge sys_clk);
        `CHK("poll", 1'b1, so)
        host.si_rise();
        `CHK("so_oe", 1'b0, so_oe)
        host.deselect();
      end
      idle();
      rdw(al[k]);
    end
    $display("test write read done");
    cmd(SEWP_OPC_WRITE_DISABLE_CMD);
    wen_m = 1'b0;
    wr(al[0], 16'hbeef);
    rdw(al[0]);
    cmd(SEWP_OPC_WRITE_ENABLE_CMD);
    wen_m = 1'b1;
    send(20, SEWP_OPC_WRITE, al[1], 16'h0f0f);
    host.deselect();
    `CHK("busy", 1'b1, rdy_busy)
    rdw(al[1]);
    $display("test enable done");
    write_lock_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    host.select();
    `CHK("lock ready", 1'b1, so)
    host.deselect();
    wr(al[2], 16'h0000);
    rdw(al[2]);
    cmd(SEWP_OPC_WRITE_DISABLE_CMD);
    wen_m = 1'b0;
    write_lock_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    wr(al[2], 16'h0000);
    write_lock_n <= 1'b1;
    cmd(SEWP_OPC_WRITE_ENABLE_CMD);
    wen_m = 1'b1;
    write_lock_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    $display("test lock done");
    d = 16'($urandom);
    wr(al[2], d);
    write_lock_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    `CHK("abort", 1'b1, rdy_busy)
    mem_m[al[2]] = SEWP_ERASED;
    write_lock_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rdw(al[2]);
    $display("test abort done");
    complete_run();
  end
endmodule
`default_nettype wire
